// ---- rtl/rif_map.svh ----
// register map and field positions of the reader interrupt flag block
// assumes an 8-bit register port with byte addresses
`ifndef RIF_MAP_SVH
`define RIF_MAP_SVH
`define RIF_ADDR_W          8
`define RIF_OFS_FLAGS0      8'h06
`define RIF_OFS_FLAGS1      8'h07
`define RIF_OFS_ENABLE0     8'h08
`define RIF_OFS_ENABLE1     8'h09
`define RIF_RST_FLAGS0      7'h00
`define RIF_RST_FLAGS1      6'h00
`define RIF_RST_ENABLE0     8'h00
`define RIF_RST_ENABLE1     8'h00
`define RIF_BIT_SETSEL      7
`define RIF_BIT_INVERT      7
`define RIF_BIT_PUSHPULL    7
`define RIF_BIT_PINGATE     6
`define RIF_BIT_GLOBAL      6
`define RIF_BIT_HIGH        6
`define RIF_BIT_LOW         5
`define RIF_BIT_DONE        4
`define RIF_BIT_TX          3
`define RIF_BIT_RX          2
`define RIF_BIT_ERR         1
`define RIF_BIT_SOF         0
`define RIF_CMD_IDLE        4'h0
`endif

// ---- rtl/rif_pkg.sv ----
// types shared by the reader interrupt flag block
package rif_pkg;
   // one-cycle event strobes and the two fifo levels from the sources of group 0
   typedef struct packed {
      logic       fifo_high_level_status;  // level, flag latches on rise
      logic       fifo_low_level_status;   // level, flag latches on rise
      logic       cmd_self_end;            // command ended by itself
      logic       cmd_unknown;             // unknown command code started
      logic       transmit_done;           // last bit sent
      logic       receive_done;            // end of stream seen
      logic       fifo_write_fault;        // error sources
      logic       fifo_overflow_fault;
      logic       protocol_fault;
      logic       empty_send_fault;
      logic       integrity_fault;
      logic       frame_start;             // start of frame detected
      logic       subcarrier;              // subcarrier detected
   } rif_src0_t;
   // strobes of group 1
   typedef struct packed {
      logic       card_detect;             // card found by low power sequence
      logic [4:0] timer_underflow;         // timer 4 down to 0
   } rif_src1_t;
   // register port request
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } rif_req_t;
endpackage : rif_pkg

// ---- rtl/reader_irq_flags.sv ----
// reader interrupt flag logic: two flag groups, enables and the request pin
// assumes sources on clk give single-cycle strobes; fifo levels are plain levels
// Functional notes
// - group0 write: bit7 sets or clears ones
// - group1 write: bit7 applied to bits 5..0
// - latch high watermark event on status rise
// - latch low watermark event on status rise
// - self-ended command sets command done event, unless a host idle start comes in the same cycle
// - unknown command returns idle, sets event unless a host idle start comes in the same cycle
// - host idle command leaves event alone
// - transmit done sets bit 3
// - receive done sets bit 2 always
// - any listed fault sets error event
// - frame start or subcarrier sets bit 0
// - enabled set flag sets combined request
// - card detect sets bit 5
// - timer underflows set bits 4..0
// - group0 enable bit7 inverts the pin level
// - group0 enables gate group0 flags
// - group0 flags zero after reset
// - pin follows the request only with pin gate; gate closed, it holds the invert level
// - group1 enables gate timer and card flags
//
// Decided for this implementation: the address-and-strobe port.
`include "rif_map.svh"
`timescale 1ns/10ps
`default_nettype none
module reader_irq_flags
   import rif_pkg::*;
(
   // clock and reset
   input  wire logic       clk,
   input  wire logic       resetn,
   // register port
   input  wire rif_req_t   req,
   output logic [7:0]      rdata,
   // event sources
   input  wire rif_src0_t  src0,
   input  wire rif_src1_t  src1,
   // host command start
   input  wire logic       cmd_start,
   input  wire logic [3:0] cmd_code,
   // command field back to idle on unknown code
   output logic            cmd_force_idle,
   // request pin, three signals
   output logic            irq_pin_o,
   output logic            irq_pin_oe,
   output logic            combined_request
);
   // flag state
   logic [6:0] flags0_q,  flags0_d;    // group0 flags
   logic [5:0] flags1_q,  flags1_d;    // group1 flags (bits 5..0)
   logic       glob_q,    glob_d;      // combined request flag
   // enable state
   logic [7:0] en0_q,     en0_d;       // group0 enable register
   logic [7:0] en1_q,     en1_d;       // group1 enable register
   // edge detect state
   logic       hi_prev_q, hi_prev_d;   // previous fifo high level
   logic       lo_prev_q, lo_prev_d;   // previous fifo low level
   // port answer and command pulse
   logic [7:0] rdata_q,   rdata_d;     // read data, one cycle later
   logic       force_q,   force_d;     // idle return pulse
   // decoded strobes
   logic [6:0] ev0;                    // group0 event set strobes
   logic [5:0] ev1;                    // group1 event set strobes
   logic       any_en;                 // some enabled flag is set
   logic       w_flags0;               // write to group0 flags
   logic       w_flags1;               // write to group1 flags
   logic       w_en0;                  // write to group0 enables
   logic       w_en1;                  // write to group1 enables
   logic [6:0] set1_full;              // group1 result before trimming

   // set/clear convention; hardware set applied after so a set wins
   function automatic logic [6:0] setclr(input logic [6:0] cur, input logic [6:0] mask,
                                         input logic sel, input logic [6:0] ev);
      logic [6:0] r;
      r = sel ? (cur | mask) : (cur & ~mask);
      setclr = r | ev;
   endfunction : setclr

   // write strobe aimed at one register; used once per writable register
   function automatic logic wr_hit(input rif_req_t r, input logic [7:0] ofs);
      wr_hit = r.wr && (r.addr == ofs);
   endfunction : wr_hit

   // unknown code is detected by the command decoder and strobed in
   wire logic host_idle = cmd_start && (cmd_code == `RIF_CMD_IDLE);

   // gather event strobes
   always_comb begin
      ev0 = '0;
      ev0[`RIF_BIT_HIGH] = src0.fifo_high_level_status & ~hi_prev_q;
      ev0[`RIF_BIT_LOW]  = src0.fifo_low_level_status & ~lo_prev_q;
      // host idle start sets nothing and also blocks a self end or unknown command in the same cycle
      ev0[`RIF_BIT_DONE] = (src0.cmd_self_end | src0.cmd_unknown) & ~host_idle;
      ev0[`RIF_BIT_TX]   = src0.transmit_done;
      ev0[`RIF_BIT_RX]   = src0.receive_done;
      ev0[`RIF_BIT_ERR]  = src0.fifo_write_fault | src0.fifo_overflow_fault |
                           src0.protocol_fault | src0.empty_send_fault |
                           src0.integrity_fault;
      ev0[`RIF_BIT_SOF]  = src0.frame_start | src0.subcarrier;
      ev1 = {src1.card_detect, src1.timer_underflow};
   end

   // gated OR over both groups, live from the flags
   assign any_en = |(flags0_q & en0_q[6:0]) | |(flags1_q & en1_q[5:0]);

   // register port decode; the port never waits, so one decode serves all
   always_comb begin
      w_flags0 = wr_hit(req, `RIF_OFS_FLAGS0);
      w_flags1 = wr_hit(req, `RIF_OFS_FLAGS1);
      w_en0    = wr_hit(req, `RIF_OFS_ENABLE0);
      w_en1    = wr_hit(req, `RIF_OFS_ENABLE1);
   end

   // group0 next value: software set/clear, then hardware events on top
   always_comb begin
      flags0_d = setclr(flags0_q, w_flags0 ? req.wdata[6:0] : 7'h00,
                        req.wdata[`RIF_BIT_SETSEL], ev0);
   end

   // group0 flags; reset leaves every flag clear
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         flags0_q <= `RIF_RST_FLAGS0;
      end else begin
         flags0_q <= flags0_d;
      end
   end

   // group1 next value; bit 6 is not stored here, so writing it does nothing
   always_comb begin
      set1_full = setclr({1'b0, flags1_q}, w_flags1 ? {1'b0, req.wdata[5:0]} : 7'h00,
                         req.wdata[`RIF_BIT_SETSEL], {1'b0, ev1});
      flags1_d  = set1_full[5:0];
   end

   // group1 flags
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         flags1_q <= `RIF_RST_FLAGS1;
      end else begin
         flags1_q <= flags1_d;
      end
   end

   // combined request follows the gated flags; software cannot force it,
   // so it drops one cycle after the last enabled flag is cleared or gated off
   always_comb begin
      glob_d = any_en;
   end

   // combined request register, one cycle behind the gated flags
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         glob_q <= 1'b0;
      end else begin
         glob_q <= glob_d;
      end
   end

   // enable registers take the whole written byte
   always_comb begin
      en0_d = w_en0 ? req.wdata : en0_q;
      en1_d = w_en1 ? req.wdata : en1_q;
   end

   // enable registers
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         en0_q <= `RIF_RST_ENABLE0;
         en1_q <= `RIF_RST_ENABLE1;
      end else begin
         en0_q <= en0_d;
         en1_q <= en1_d;
      end
   end

   // level history for the watermark edge detectors
   always_comb begin
      hi_prev_d = src0.fifo_high_level_status;
      lo_prev_d = src0.fifo_low_level_status;
   end

   // level history; reset to the idle level low avoids a false edge
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         hi_prev_q <= 1'b0;
         lo_prev_q <= 1'b0;
      end else begin
         hi_prev_q <= hi_prev_d;
         lo_prev_q <= lo_prev_d;
      end
   end

   // idle return pulse follows an unknown command by one cycle
   always_comb begin
      force_d = src0.cmd_unknown;
   end

   // idle return pulse register
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         force_q <= 1'b0;
      end else begin
         force_q <= force_d;
      end
   end

   // read data; reads have no side effect on any flag
   always_comb begin
      rdata_d = 8'h00;
      if (req.rd) begin
         case (req.addr)
            `RIF_OFS_FLAGS0:  rdata_d = {1'b0, flags0_q};
            `RIF_OFS_FLAGS1:  rdata_d = {1'b0, glob_q, flags1_q};
            `RIF_OFS_ENABLE0: rdata_d = en0_q;
            `RIF_OFS_ENABLE1: rdata_d = en1_q;
            default:          rdata_d = 8'h00;                         // unmapped reads zero
         endcase
      end
   end

   // read data register; zero outside the answer cycle
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign rdata          = rdata_q;
   assign cmd_force_idle = force_q;
   assign combined_request = glob_q;

   // pin: active-high request, inverted on demand; open drain drives only the low level
   wire logic pin_lvl = (glob_q & en1_q[`RIF_BIT_PINGATE]) ^ en0_q[`RIF_BIT_INVERT];
   assign irq_pin_o  = pin_lvl;
   assign irq_pin_oe = en1_q[`RIF_BIT_PUSHPULL] | ~pin_lvl;

   // checks
   AST_SET0: assert property (@(posedge clk) disable iff (!resetn)
      (req.wr && req.addr == `RIF_OFS_FLAGS0 && req.wdata == 8'hFF) |=> (flags0_q == 7'h7F))
      else $error("group0 set-all write failed");
   AST_CLR1: assert property (@(posedge clk) disable iff (!resetn)
      (req.wr && req.addr == `RIF_OFS_FLAGS1 && req.wdata == 8'h3F && ev1 == 6'h00)
      |=> (flags1_q == 6'h00))
      else $error("group1 clear write failed");
   AST_HIGH: assert property (@(posedge clk) disable iff (!resetn)
      $rose(src0.fifo_high_level_status) |=> flags0_q[`RIF_BIT_HIGH])
      else $error("high watermark not latched");
   AST_LOW: assert property (@(posedge clk) disable iff (!resetn)
      $rose(src0.fifo_low_level_status) |=> flags0_q[`RIF_BIT_LOW])
      else $error("low watermark not latched");
   AST_IDLE: assert property (@(posedge clk) disable iff (!resetn)
      (host_idle && !src0.cmd_self_end && !src0.cmd_unknown && !req.wr)
      |=> (flags0_q[`RIF_BIT_DONE] == $past(flags0_q[`RIF_BIT_DONE])))
      else $error("host idle changed done flag");
   AST_UNK: assert property (@(posedge clk) disable iff (!resetn)
      (src0.cmd_unknown && !host_idle) |=> (cmd_force_idle && flags0_q[`RIF_BIT_DONE]))
      else $error("unknown command not handled");
   AST_ERR: assert property (@(posedge clk) disable iff (!resetn)
      src0.protocol_fault |=> flags0_q[`RIF_BIT_ERR])
      else $error("error event missing");
   AST_GLOB: assert property (@(posedge clk) disable iff (!resetn)
      ((flags0_q & en0_q[6:0]) != 7'h00) |=> glob_q)
      else $error("combined request not set");
   AST_PIN: assert property (@(posedge clk) disable iff (!resetn)
      (!en1_q[`RIF_BIT_PINGATE]) |-> (irq_pin_o == en0_q[`RIF_BIT_INVERT]))
      else $error("pin driven without gate");
   AST_RDZ: assert property (@(posedge clk) disable iff (!resetn)
      (req.rd && req.addr == `RIF_OFS_FLAGS0) |=> (rdata[7] == 1'b0))
      else $error("selector read nonzero");

   // multi-step checks: a watermark level rises, falls again, flag must stay
   sequence seq_high_pulse;
      $rose(src0.fifo_high_level_status) ##1 !src0.fifo_high_level_status;
   endsequence : seq_high_pulse
   sequence seq_low_pulse;
      $rose(src0.fifo_low_level_status) ##1 !src0.fifo_low_level_status;
   endsequence : seq_low_pulse
   sequence seq_no_g0_write;
      !w_flags0 [*2];
   endsequence : seq_no_g0_write
   AST_HOLD: assert property (@(posedge clk) disable iff (!resetn)
      (seq_high_pulse and seq_no_g0_write) |=> flags0_q[`RIF_BIT_HIGH])
      else $error("high watermark flag not held");
   AST_LOWHOLD: assert property (@(posedge clk) disable iff (!resetn)
      (seq_low_pulse and seq_no_g0_write) |=> flags0_q[`RIF_BIT_LOW])
      else $error("low watermark flag not held");

   // software set and clear of both groups
   AST_CLR0: assert property (@(posedge clk) disable iff (!resetn)
      (w_flags0 && req.wdata == 8'h7F && ev0 == 7'h00) |=> (flags0_q == 7'h00))
      else $error("group0 clear-all write failed");
   AST_KEEP0: assert property (@(posedge clk) disable iff (!resetn)
      (w_flags0 && req.wdata[6:0] == 7'h00 && ev0 == 7'h00)
      |=> (flags0_q == $past(flags0_q)))
      else $error("group0 zero write changed flags");
   AST_SET1: assert property (@(posedge clk) disable iff (!resetn)
      (w_flags1 && req.wdata == 8'hFF) |=> (flags1_q == 6'h3F))
      else $error("group1 set-all write failed");

   // hardware events land one cycle after their strobe
   AST_TMR: assert property (@(posedge clk) disable iff (!resetn)
      src1.timer_underflow[0] |=> flags1_q[0])
      else $error("timer underflow flag missing");
   AST_CARD: assert property (@(posedge clk) disable iff (!resetn)
      src1.card_detect |=> flags1_q[5])
      else $error("card detect flag missing");
   AST_TXD: assert property (@(posedge clk) disable iff (!resetn)
      src0.transmit_done |=> flags0_q[`RIF_BIT_TX])
      else $error("transmit done flag missing");
   AST_RXD: assert property (@(posedge clk) disable iff (!resetn)
      src0.receive_done |=> flags0_q[`RIF_BIT_RX])
      else $error("receive done flag missing");
   AST_SOF: assert property (@(posedge clk) disable iff (!resetn)
      (src0.frame_start || src0.subcarrier) |=> flags0_q[`RIF_BIT_SOF])
      else $error("frame start flag missing");
   AST_DONE: assert property (@(posedge clk) disable iff (!resetn)
      (src0.cmd_self_end && !host_idle) |=> flags0_q[`RIF_BIT_DONE])
      else $error("command done flag missing");
   AST_FORCE: assert property (@(posedge clk) disable iff (!resetn)
      cmd_force_idle |-> $past(src0.cmd_unknown))
      else $error("idle return without unknown command");

   // reads, the combined request and the pin
   AST_RDKEEP: assert property (@(posedge clk) disable iff (!resetn)
      (req.rd && !w_flags0 && ev0 == 7'h00)
      |=> (flags0_q == $past(flags0_q)))
      else $error("read changed group0 flags");
   AST_GLOBF: assert property (@(posedge clk) disable iff (!resetn)
      1'b1 |=> (glob_q == $past(any_en)))
      else $error("combined request not following gated flags");
   AST_GATE1: assert property (@(posedge clk) disable iff (!resetn)
      ((flags1_q & en1_q[5:0]) != 6'h00) |=> glob_q)
      else $error("group1 gated flag did not raise request");
   AST_INV: assert property (@(posedge clk) disable iff (!resetn)
      en1_q[`RIF_BIT_PINGATE] |-> (irq_pin_o == (glob_q ^ en0_q[`RIF_BIT_INVERT])))
      else $error("pin level wrong with gate open");
   AST_OE: assert property (@(posedge clk) disable iff (!resetn)
      en1_q[`RIF_BIT_PUSHPULL] |-> irq_pin_oe)
      else $error("push-pull pin not driven");
   AST_RDZ1: assert property (@(posedge clk) disable iff (!resetn)
      (req.rd && req.addr == `RIF_OFS_FLAGS1) |=> (rdata[7] == 1'b0))
      else $error("group1 selector read nonzero");
endmodule : reader_irq_flags
`default_nettype wire

// ---- test/rif_host_model.sv ----
// host model: the controller side of the flag block's register port
// assumes the block samples req at posedge clk and answers reads a cycle later
`timescale 1ns/10ps
`default_nettype none
module rif_host_model
   import rif_pkg::*;
(
   // clock
   input  wire logic       clk,
   // register port
   output var  rif_req_t   req,
   input  wire logic [7:0] rdata
);
   // bus idle at time zero
   initial req = '0;
   // one-cycle write; released lines show inverted values, not stale ones
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      req <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
   endtask : wr
   // one-cycle read; data stand only in the following cycle
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      req <= '{addr: ~a, wdata: 8'hFF, wr: 1'b0, rd: 1'b0};
      #1 d = rdata;
   endtask : rd
endmodule : rif_host_model
`default_nettype wire

// ---- test/tb_top.sv ----
// testbench of the reader interrupt flag block
// assumes the host model above; sources are driven here as one-cycle strobes
`timescale 1ns/10ps
`default_nettype none
module tb_top
   import rif_pkg::*;
;
   // one table row: strobes and the flags they should leave behind
   typedef struct packed {
      rif_src0_t  s0;
      rif_src1_t  s1;
      logic [7:0] f0;
      logic [7:0] f1;
   } rif_row_t;
   logic       clk, resetn, cmd_start, cmd_force_idle;
   logic       irq_pin_o, irq_pin_oe, combined_request;
   logic [3:0] cmd_code;
   logic [7:0] rdata, d;
   rif_req_t   req;
   rif_src0_t  src0;
   rif_src1_t  src1;
   int         fails, tests_run, cycles;
   rif_row_t   rows [19] = '{
      '{13'h1000, 6'h00, 8'h40, 8'h00}, '{13'h0800, 6'h00, 8'h20, 8'h00},
      '{13'h0400, 6'h00, 8'h10, 8'h00}, '{13'h0200, 6'h00, 8'h10, 8'h00},
      '{13'h0100, 6'h00, 8'h08, 8'h00}, '{13'h0080, 6'h00, 8'h04, 8'h00},
      '{13'h0040, 6'h00, 8'h02, 8'h00}, '{13'h0020, 6'h00, 8'h02, 8'h00},
      '{13'h0010, 6'h00, 8'h02, 8'h00}, '{13'h0008, 6'h00, 8'h02, 8'h00},
      '{13'h0004, 6'h00, 8'h02, 8'h00}, '{13'h0002, 6'h00, 8'h01, 8'h00},
      '{13'h0001, 6'h00, 8'h01, 8'h00}, '{13'h0000, 6'h20, 8'h00, 8'h20},
      '{13'h0000, 6'h10, 8'h00, 8'h10}, '{13'h0000, 6'h08, 8'h00, 8'h08},
      '{13'h0000, 6'h04, 8'h00, 8'h04}, '{13'h0000, 6'h02, 8'h00, 8'h02},
      '{13'h0000, 6'h01, 8'h00, 8'h01}};
   reader_irq_flags uut (.clk(clk), .resetn(resetn), .req(req), .rdata(rdata),
      .src0(src0), .src1(src1), .cmd_start(cmd_start), .cmd_code(cmd_code),
      .cmd_force_idle(cmd_force_idle), .irq_pin_o(irq_pin_o),
      .irq_pin_oe(irq_pin_oe), .combined_request(combined_request));
   rif_host_model host (.clk(clk), .req(req), .rdata(rdata));
   // 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // compare and count
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // one-cycle strobe on the sources
   task automatic pulse(input rif_src0_t a, input rif_src1_t b);
      @(posedge clk);
      src0 <= a;
      src1 <= b;
      @(posedge clk);
      src0 <= '0;
      src1 <= '0;
   endtask : pulse
   // let flags and the combined request settle
   task automatic settle;
      repeat (4) @(posedge clk);
      #1;
   endtask : settle
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : give_verdict
   // hang guard, well above the few hundred cycles the run needs
   initial begin
      cycles = 0;
      forever begin
         @(posedge clk);
         cycles++;
         if (cycles == 5000) begin
            fails++;
            give_verdict;
         end
      end
   end
   initial begin
      fails = 0;
      tests_run = 0;
      resetn = 1'b0;
      src0 = '0;
      src1 = '0;
      cmd_start = 1'b0;
      cmd_code = 4'h0;
      repeat (6) @(posedge clk);
      resetn <= 1'b1;
      // each source alone; level statuses drop again, so their flags must hold
      foreach (rows[i]) begin
         host.wr(8'h06, 8'h7F);
         host.wr(8'h07, 8'h3F);
         pulse(rows[i].s0, rows[i].s1);
         host.rd(8'h06, d);
         chk(d, rows[i].f0);
         host.rd(8'h07, d);
         chk(d, rows[i].f1);
      end
      $display("done: sources");
      host.wr(8'h06, 8'hFF);
      host.rd(8'h06, d);
      chk(d, 8'h7F);
      host.wr(8'h06, 8'h05);
      host.rd(8'h06, d);
      chk(d, 8'h7A);
      host.wr(8'h06, 8'h81);
      host.rd(8'h06, d);
      chk(d, 8'h7B);
      host.wr(8'h07, 8'hFF);
      host.rd(8'h07, d);
      chk(d, 8'h3F);
      host.wr(8'h07, 8'h21);
      host.rd(8'h07, d);
      chk(d, 8'h1E);
      host.wr(8'h06, 8'h7F);
      host.wr(8'h07, 8'h3F);
      $display("done: set and clear");
      // gated request: pin stays low until its gate opens
      host.wr(8'h08, 8'h04);
      host.wr(8'h06, 8'h84);
      settle;
      chk(combined_request, 1'b1);
      host.rd(8'h07, d);
      chk(d, 8'h40);
      host.rd(8'h06, d);
      chk(d, 8'h04);
      chk({irq_pin_o, irq_pin_oe}, 2'b01);
      host.wr(8'h09, 8'h40);
      settle;
      chk({irq_pin_o, irq_pin_oe}, 2'b10);
      host.wr(8'h09, 8'hC0);
      settle;
      chk({irq_pin_o, irq_pin_oe}, 2'b11);
      host.wr(8'h08, 8'h84);
      settle;
      chk({irq_pin_o, irq_pin_oe}, 2'b01);
      host.wr(8'h08, 8'h00);
      host.wr(8'h07, 8'h40);
      settle;
      chk(combined_request, 1'b0);
      host.wr(8'h09, 8'h01);
      pulse('0, 6'h02);
      settle;
      chk(combined_request, 1'b0);
      pulse('0, 6'h01);
      settle;
      chk(combined_request, 1'b1);
      $display("done: request and pin");
      // host idle start in the same cycle as a self-ended command
      host.wr(8'h06, 8'h7F);
      @(posedge clk);
      cmd_start <= 1'b1;
      src0.cmd_self_end <= 1'b1;
      @(posedge clk);
      cmd_start <= 1'b0;
      src0.cmd_self_end <= 1'b0;
      host.rd(8'h06, d);
      chk(d, 8'h00);
      pulse(13'h0200, '0);
      #1 chk(cmd_force_idle, 1'b1);
      // host idle start alone must leave a set done flag as it is
      host.wr(8'h06, 8'h90);
      @(posedge clk);
      cmd_start <= 1'b1;
      @(posedge clk);
      cmd_start <= 1'b0;
      host.rd(8'h06, d);
      chk(d, 8'h10);
      $display("done: commands");
      // second reset in mid-run with flags set
      host.wr(8'h06, 8'hFF);
      resetn <= 1'b0;
      repeat (6) @(posedge clk);
      resetn <= 1'b1;
      host.rd(8'h06, d);
      chk(d, 8'h00);
      host.rd(8'h0A, d);
      chk(d, 8'h00);
      $display("done: reset");
      give_verdict;
   end
endmodule : tb_top
`default_nettype wire
